// ### core/fault_log_pkg.sv
package fault_log_pkg;

   // ==========================================================
   // Block read framing
   // ==========================================================
   localparam logic [7:0] BYTE_COUNT_VAL = 8'hFF;
   localparam logic [7:0] PTR_POS        = 8'h00;
   localparam logic [7:0] TS_FIRST_POS   = 8'h01;
   localparam logic [7:0] TS_LAST_POS    = 8'h06;
   localparam logic [7:0] PM_FIRST_POS   = 8'h07;
   localparam logic [7:0] PREAMBLE_LEN   = 8'h2F;  // 47 bytes, positions 0..46
   localparam logic [7:0] CYC_LAST_POS   = 8'hED;  // 237, last cyclic byte
   localparam logic [7:0] RSV_LAST_POS   = 8'hFE;  // 254, end of reserved tail

   // ==========================================================
   // Preamble fields
   // ==========================================================
   localparam int TS_W      = 41;  // Counter LSB is 200 us
   localparam int PM_WORDS  = 20;  // Peak and minimum words, 16 bits each

   // ==========================================================
   // Cyclic telemetry loop
   // ==========================================================
   localparam logic [5:0] LOOP_LAST  = 6'h27;  // 40 entries, 0..39
   localparam logic [5:0] RSV_VIN    = 6'h0B;  // Byte after input-voltage group
   localparam logic [5:0] RSV_TEMP   = 6'h17;  // Byte after temperature group
   localparam logic [7:0] ZERO_BYTE  = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_COUNT = 2'b01,
      ST_DATA  = 2'b10,
      ST_DONE  = 2'b11
   } rd_state_t;

   function automatic logic is_reserved(input logic [5:0] entry);
      is_reserved = (entry == RSV_VIN) || (entry == RSV_TEMP);
   endfunction

endpackage

// ### core/fault_log_readout.sv
`timescale 1ns/1ps

// Functional notes
// - Preamble of 47 bytes precedes cyclic data
// - Cyclic bytes 47..237; 238..254 reserved
// - Send count 0xFF, then pointer first
// - Byte 47 is pointer entry, then descending
// - Forty entries in groups of four
// - Byte 0 holds write pointer at fault
// - Bytes 1..6 hold 41-bit timestamp, LSB first
// - Peak/minimum words low byte first, to 46
module fault_log_readout
   import fault_log_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    arst_n,
   input  wire logic                    rd_start,
   input  wire logic                    byte_req,
   input  wire logic [7:0]              position_last,
   input  wire logic [TS_W-1:0]         fault_timestamp,
   input  wire logic [PM_WORDS*16-1:0]  pm_words,
   input  wire logic [7:0]              tele_data,
   output logic                         tele_rd,
   output logic      [5:0]              tele_entry,
   output logic      [2:0]              tele_age,
   output logic      [7:0]              byte_data,
   output logic                         byte_valid
);

   // ==========================================================
   // State
   // ==========================================================
   rd_state_t   state_r;
   rd_state_t   state_nxt;
   logic [7:0]  pos_r;
   logic [5:0]  entry_r;
   logic [2:0]  age_r;
   logic [7:0]  byte_data_r;
   logic [7:0]  byte_data_nxt;
   logic        byte_valid_r;

   // ==========================================================
   // Decode and byte selection
   // ==========================================================
   wire         req_count  = (state_r == ST_COUNT) && byte_req;
   wire         req_data   = (state_r == ST_DATA) && byte_req;
   wire         in_pre     = pos_r < PREAMBLE_LEN;
   wire         in_cyc     = !in_pre && (pos_r <= CYC_LAST_POS);
   wire         cyc_req    = req_data && in_cyc;
   wire         last_pos   = pos_r == RSV_LAST_POS;
   wire [47:0]  ts_ext     = {{(48-TS_W){1'b0}}, fault_timestamp};
   wire [7:0]   ts_idx     = pos_r - TS_FIRST_POS;
   wire [7:0]   pm_idx     = pos_r - PM_FIRST_POS;
   wire [7:0]   ts_byte    = ts_ext[ts_idx[2:0]*8 +: 8];
   wire [7:0]   pm_byte    = pm_words[pm_idx[5:0]*8 +: 8];
   wire         entry_zero = entry_r == 6'h00;
   wire [5:0]   entry_dec  = entry_zero ? LOOP_LAST : entry_r - 6'h01;
   wire [7:0]   pre_byte   = (pos_r == PTR_POS)     ? position_last :
                             (pos_r <= TS_LAST_POS) ? ts_byte       :
                                                      pm_byte;
   wire [7:0]   cyc_byte   = is_reserved(entry_r) ? ZERO_BYTE : tele_data;
   wire [7:0]   data_byte  = in_pre ? pre_byte :
                             in_cyc ? cyc_byte : ZERO_BYTE;

   assign tele_rd    = cyc_req;
   assign tele_entry = entry_r;
   assign tele_age   = age_r;
   assign byte_data  = byte_data_r;
   assign byte_valid = byte_valid_r;

   always_comb begin
      state_nxt     = state_r;
      byte_data_nxt = byte_data_r;
      if (rd_start) begin
         state_nxt = ST_COUNT;
      end else begin
         case (state_r)
            ST_COUNT: begin
               if (byte_req) begin
                  state_nxt     = ST_DATA;
                  byte_data_nxt = BYTE_COUNT_VAL;
               end
            end
            ST_DATA: begin
               if (byte_req) begin
                  byte_data_nxt = data_byte;
                  if (last_pos) begin
                     state_nxt = ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               if (byte_req) begin
                  byte_data_nxt = ZERO_BYTE;
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r      <= ST_IDLE;
         byte_data_r  <= ZERO_BYTE;
         byte_valid_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         byte_data_r  <= byte_data_nxt;
         byte_valid_r <= byte_req && (state_r != ST_IDLE) && !rd_start;
      end
   end

   // Pointer is loaded on the count byte so it may change up to then
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_r   <= 8'h00;
         entry_r <= 6'h00;
         age_r   <= 3'h0;
      end else if (rd_start) begin
         pos_r   <= 8'h00;
         age_r   <= 3'h0;
      end else if (req_count) begin
         entry_r <= position_last[5:0];
      end else if (req_data) begin
         pos_r <= pos_r + 8'h01;
         if (cyc_req) begin
            entry_r <= entry_dec;
            age_r   <= entry_zero ? age_r + 3'h1 : age_r;
         end
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================

   // Pointer seen at the count byte; requests may have gaps, so no fixed $past depth
   logic [5:0]  ptr_cap_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_cap_r <= 6'h00;
      end else if (req_count && !rd_start) begin
         ptr_cap_r <= position_last[5:0];
      end
   end
   property p_count;
      @(posedge sys_clk) disable iff (!arst_n)
      (req_count && !rd_start) |=> (byte_valid && byte_data == 8'hFF);
   endproperty
   a_count: assert property (p_count) else $error("count byte not 0xFF");

   property p_ptr;
      @(posedge sys_clk) disable iff (!arst_n)
      (req_data && !rd_start && pos_r == 8'h00) |=> (byte_data == $past(position_last));
   endproperty
   a_ptr: assert property (p_ptr) else $error("first data byte not pointer");

   property p_ts;
      @(posedge sys_clk) disable iff (!arst_n)
      (req_data && !rd_start && pos_r == 8'h06) |=> (byte_data == {7'h00, $past(fault_timestamp[40])});
   endproperty
   a_ts: assert property (p_ts) else $error("timestamp top byte wrong");

   property p_pm;
      @(posedge sys_clk) disable iff (!arst_n)
      (req_data && !rd_start && pos_r == 8'h2E) |=> (byte_data == $past(pm_words[319:312]));
   endproperty
   a_pm: assert property (p_pm) else $error("byte 46 not last min high byte");

   property p_pre_len;
      @(posedge sys_clk) disable iff (!arst_n)
      (byte_req && pos_r < 8'h2F) |-> !tele_rd;
   endproperty
   a_pre_len: assert property (p_pre_len) else $error("store read inside preamble");

   property p_entry;
      @(posedge sys_clk) disable iff (!arst_n)
      (cyc_req && pos_r == PREAMBLE_LEN) |-> (tele_entry == ptr_cap_r);
   endproperty
   a_entry: assert property (p_entry) else $error("byte 47 not pointer entry");

   property p_walk;
      @(posedge sys_clk) disable iff (!arst_n)
      (cyc_req && !rd_start && tele_entry == 6'h00) |=> (tele_entry == 6'h27 && tele_age == $past(tele_age) + 3'h1);
   endproperty
   a_walk: assert property (p_walk) else $error("loop wrap wrong");

   property p_rsv;
      @(posedge sys_clk) disable iff (!arst_n)
      (cyc_req && !rd_start && is_reserved(tele_entry)) |=> (byte_data == 8'h00);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved entry not zero");

   property p_tail;
      @(posedge sys_clk) disable iff (!arst_n)
      (req_data && !rd_start && pos_r > 8'hED) |=> (byte_valid && byte_data == 8'h00 && !$past(tele_rd));
   endproperty
   a_tail: assert property (p_tail) else $error("reserved tail not zero");

   property p_cyc_rd;
      @(posedge sys_clk) disable iff (!arst_n)
      (req_data && pos_r >= PREAMBLE_LEN && pos_r <= CYC_LAST_POS) |-> tele_rd;
   endproperty
   a_cyc_rd: assert property (p_cyc_rd) else $error("cyclic byte without store read");

   property p_cyc_data;
      @(posedge sys_clk) disable iff (!arst_n)
      (cyc_req && !rd_start && !is_reserved(tele_entry)) |=> (byte_data == $past(tele_data));
   endproperty
   a_cyc_data: assert property (p_cyc_data) else $error("cyclic byte not store data");

   property p_desc;
      @(posedge sys_clk) disable iff (!arst_n)
      (cyc_req && !rd_start && tele_entry != 6'h00) |=> (tele_entry == $past(tele_entry) - 6'h01);
   endproperty
   a_desc: assert property (p_desc) else $error("loop entry did not step down");

   property p_refuse;
      @(posedge sys_clk) disable iff (!arst_n)
      (rd_start || state_r == ST_IDLE) |=> !byte_valid;
   endproperty
   a_refuse: assert property (p_refuse) else $error("byte answered outside a read");

endmodule // fault_log_readout

// ### bench/fault_log_host.sv
`timescale 1ns/1ps

// ====================
// Host side of a block read
module fault_log_host (
   input  wire logic sys_clk,
   output logic      rd_start,
   output logic      byte_req
);
   initial begin
      rd_start = 1'b0;
      byte_req = 1'b0;
   end

   // Framing pulse of one cycle; the clash read issues it on the same edge as the first request
   task automatic start();
      @(posedge sys_clk) rd_start <= 1'b1;
      @(posedge sys_clk) rd_start <= 1'b0;
   endtask

   // Back to back; request n+1 carries data byte n, counted from 1
   task automatic request(input int n);
      repeat (n) @(posedge sys_clk) byte_req <= 1'b1;
      @(posedge sys_clk) byte_req <= 1'b0;
   endtask
endmodule // fault_log_host

// ### bench/test_fault_log_readout.sv
`timescale 1ns/1ps

// ====================
// Block read bench
module test_fault_log_readout
   import fault_log_pkg::*;
;
   logic                   sys_clk, arst_n, rd_start, byte_req, tele_rd, byte_valid;
   logic [7:0]             position_last, tele_data, byte_data;
   logic [TS_W-1:0]        fault_timestamp;
   logic [PM_WORDS*16-1:0] pm_words;
   logic [5:0]             tele_entry;
   logic [2:0]             tele_age;
   logic [31:0]            seed = 32'hdfb5_49a4;
   logic [7:0]             exp_q[$];
   int                     pos_q[$];
   int                     bad_count, total_checks;

   fault_log_readout u_fault_log_readout (.sys_clk(sys_clk), .arst_n(arst_n),
      .rd_start(rd_start), .byte_req(byte_req), .position_last(position_last),
      .fault_timestamp(fault_timestamp), .pm_words(pm_words), .tele_data(tele_data),
      .tele_rd(tele_rd), .tele_entry(tele_entry), .tele_age(tele_age),
      .byte_data(byte_data), .byte_valid(byte_valid));
   fault_log_host u_fault_log_host (.sys_clk(sys_clk), .rd_start(rd_start),
      .byte_req(byte_req));

   // Store answers with entry and loop age, so a wrong age shows
   assign tele_data = tele_rd ? ({tele_age, 5'h00} + {2'h0, tele_entry}) : 8'hA5;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] exp_byte(input int pos);
      int          k, e, a, p;
      logic [47:0] t;
      t = {7'h00, fault_timestamp};
      p = int'(position_last);
      if (pos < 0) return 8'hFF;
      if (pos == 0) return position_last;
      if (pos <= 6) return t[8*(pos-1)+:8];
      if (pos <= 46) return pm_words[8*(pos-7)+:8];
      if (pos > 237) return 8'h00;
      k = pos - 47;
      e = ((p - k) % 40 + 40) % 40;
      a = (k <= p) ? 0 : (k - p - 1) / 40 + 1;
      if (e == 11 || e == 23) return 8'h00;
      return 8'(a * 32 + e);
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic load(input int p);
      @(posedge sys_clk);
      position_last <= 8'(p);
      fault_timestamp <= TS_W'({xs(), xs()});
      for (int i = 0; i < PM_WORDS / 2; i++) pm_words[32*i+:32] <= xs();
      @(posedge sys_clk);
   endtask

   task automatic read(input int n, input bit clash);
      for (int i = -1; i < n - 1; i++) begin
         exp_q.push_back(exp_byte(i));
         pos_q.push_back(i);
      end
      if (clash) begin
         // First request shares the edge with rd_start and must be dropped
         fork
            u_fault_log_host.start();
            u_fault_log_host.request(n + 1);
         join
      end else begin
         u_fault_log_host.start();
         u_fault_log_host.request(n);
      end
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic finish_test();
      if (exp_q.size() != 0) bad_count++;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ====================
   // Output watcher
   always @(posedge sys_clk) begin
      if (arst_n === 1'b1 && byte_valid === 1'b1) begin
         if (exp_q.size() == 0) check({7'h00, byte_valid}, 8'h00);
         else if (pos_q.pop_front() < 47) check(byte_data, exp_q.pop_front());
         else check(byte_data, exp_q.pop_front());
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      finish_test();
   end

   // ====================
   // Scenarios: refused requests, edge pointers, restart, tail past 254
   initial begin
      arst_n = 1'b0;
      position_last = 8'h00;
      fault_timestamp = '0;
      pm_words = '0;
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      u_fault_log_host.request(3);
      load(9);
      read(20, 1'b0);
      read(258, 1'b0);
      load(0);
      read(258, 1'b1);
      load(39);
      read(258, 1'b0);
      for (int r = 0; r < 2; r++) begin
         load(int'(xs() % 40));
         read(258, r == 1);
      end
      finish_test();
   end
endmodule // test_fault_log_readout
